// ==== rtl/serial_bus_user_access_bridge.sv ====
// Operation
// - after configuring, reply 05 on success or 06 on failure, then module address
// - one or several value bytes accepted, applied in order from given address
// - a user write never produces any reply message
// - write: address under address strobe, then each value under data strobe with write
// - read reply is opcode 10, module address, then data bytes to requester
// - read: address under address strobe, then data collected under strobes, write low
// - message formats for user write and read are enforced; malformed ones dropped
// - answer only frames for own address: board switch high four, slot low three
`timescale 1ns/1ps
`include "bridge_map.svh"
module serial_bus_user_access_bridge
   import bridge_pkg::*;
(
   input wire logic clk_in,
   input wire logic rstn_in,
   input wire logic [`BOARD_FIELD_W-1:0] board_num_in,
   input wire logic [`SLOT_FIELD_W-1:0] slot_num_in,
   input wire logic rx_valid_in,
   input wire logic [7:0] rx_data_in,
   input wire logic rx_last_in,
   output logic rx_ready_out,
   output logic tx_valid_out,
   output logic [7:0] tx_data_out,
   output logic tx_last_out,
   input wire logic tx_ready_in,
   output logic cfg_valid_out,
   output logic [7:0] cfg_data_out,
   output logic cfg_last_out,
   input wire logic cfg_done_in,
   input wire logic cfg_ok_in,
   output logic [7:0] app_addr_out,
   output logic app_addr_stb_out,
   output logic [7:0] app_data_out,
   output logic app_data_stb_out,
   output logic app_write_out,
   input wire logic [7:0] app_rdata_in
);
   bridge_state_type state_reg, state_next;
   logic [7:0] op_reg, op_next, addr_reg, addr_next, data_reg, data_next;
   logic [7:0] cnt_reg, cnt_next, tx_data_reg, tx_data_next, cfg_data_reg, cfg_data_next;
   logic [`BUS_ADDR_MSB:0] req_reg, req_next, own_addr;
   logic first_reg, first_next, last_reg, last_next, ok_reg, ok_next;
   logic tx_last_reg, tx_last_next, astb_reg, astb_next, dstb_reg, dstb_next;
   logic write_reg, write_next, cfg_valid_reg, cfg_valid_next, cfg_last_reg, cfg_last_next;
   logic rx_take, tx_take;

   // ------------------------------------------------------------
   // own bus address
   // ------------------------------------------------------------
   addr_sync #(
      .WIDTH(`BUS_ADDR_MSB + 1),
      .STAGES(`SYNC_STAGES_DEFAULT)
   ) u_addr_sync (
      .clk_in(clk_in),
      .rstn_in(rstn_in),
      .async_in({board_num_in, slot_num_in}),
      .sync_out(own_addr)
   );

   // ------------------------------------------------------------
   // handshakes
   // ------------------------------------------------------------
   always_comb begin
      unique case (state_reg)
         st_dest, st_opcode, st_requester, st_skip, st_cfg_byte,
         st_wr_addr, st_wr_value, st_rd_addr, st_rd_len: rx_ready_out = 1'b1;
         default: rx_ready_out = 1'b0;
      endcase
   end
   assign tx_valid_out = (state_reg == st_tx_dest) || (state_reg == st_tx_opcode) ||
                         (state_reg == st_tx_module) || (state_reg == st_tx_data);
   assign rx_take = rx_ready_out && rx_valid_in;
   assign tx_take = tx_valid_out && tx_ready_in;

   // ------------------------------------------------------------
   // message sequencer
   // ------------------------------------------------------------
   always_comb begin
      state_next = state_reg;
      op_next = op_reg;
      req_next = req_reg;
      addr_next = addr_reg;
      data_next = data_reg;
      cnt_next = cnt_reg;
      first_next = first_reg;
      last_next = last_reg;
      ok_next = ok_reg;
      tx_data_next = tx_data_reg;
      tx_last_next = tx_last_reg;
      cfg_data_next = cfg_data_reg;
      astb_next = 1'b0;
      dstb_next = 1'b0;
      write_next = 1'b0;
      cfg_valid_next = 1'b0;
      cfg_last_next = 1'b0;
      unique case (state_reg)
         st_dest: begin
            if (rx_take && !rx_last_in) begin
               state_next = (rx_data_in == {1'b0, own_addr}) ? st_opcode : st_skip;
            end
         end
         st_opcode: begin
            if (rx_take) begin
               op_next = rx_data_in;
               if (rx_last_in) begin
                  state_next = st_dest;
               end else if (rx_data_in == `OPC_CONFIGURE || rx_data_in == `OPC_USER_WRITE ||
                            rx_data_in == `OPC_USER_READ) begin
                  state_next = st_requester;
               end else begin
                  state_next = st_skip;
               end
            end
         end
         st_requester: begin
            if (rx_take) begin
               req_next = rx_data_in[`BUS_ADDR_MSB:0];
               if (op_reg == `OPC_CONFIGURE) begin
                  ok_next = 1'b0;
                  tx_data_next = {1'b0, rx_data_in[`BUS_ADDR_MSB:0]};
                  tx_last_next = 1'b0;
                  state_next = rx_last_in ? st_tx_dest : st_cfg_byte;
               end else if (rx_last_in) begin
                  state_next = st_dest;
               end else begin
                  state_next = (op_reg == `OPC_USER_WRITE) ? st_wr_addr : st_rd_addr;
               end
            end
         end
         st_skip: begin
            if (rx_take && rx_last_in) begin
               state_next = st_dest;
            end
         end
         st_cfg_byte: begin
            if (rx_take) begin
               cfg_valid_next = 1'b1;
               cfg_data_next = rx_data_in;
               cfg_last_next = rx_last_in;
               if (rx_last_in) begin
                  state_next = st_cfg_wait;
               end
            end
         end
         st_cfg_wait: begin
            if (cfg_done_in) begin
               ok_next = cfg_ok_in;
               tx_data_next = {1'b0, req_reg};
               tx_last_next = 1'b0;
               state_next = st_tx_dest;
            end
         end
         st_wr_addr: begin
            if (rx_take) begin
               addr_next = rx_data_in;
               first_next = 1'b1;
               state_next = rx_last_in ? st_dest : st_wr_value;
            end
         end
         st_wr_value: begin
            if (rx_take) begin
               data_next = rx_data_in;
               first_next = 1'b0;
               if (first_reg) begin
                  astb_next = 1'b1;
                  write_next = 1'b1;
                  last_next = rx_last_in;
                  state_next = st_wr_put;
               end else begin
                  dstb_next = 1'b1;
                  write_next = 1'b1;
                  state_next = rx_last_in ? st_dest : st_wr_value;
               end
            end
         end
         st_wr_put: begin
            dstb_next = 1'b1;
            write_next = 1'b1;
            state_next = last_reg ? st_dest : st_wr_value;
         end
         st_rd_addr: begin
            if (rx_take) begin
               addr_next = rx_data_in;
               state_next = rx_last_in ? st_dest : st_rd_len;
            end
         end
         st_rd_len: begin
            if (rx_take) begin
               cnt_next = rx_data_in;
               tx_data_next = {1'b0, req_reg};
               tx_last_next = 1'b0;
               if (!rx_last_in) begin
                  state_next = st_skip;
               end else if (rx_data_in == `BYTE_RESET) begin
                  state_next = st_dest;
               end else begin
                  state_next = st_tx_dest;
               end
            end
         end
         st_tx_dest: begin
            if (tx_take) begin
               if (op_reg == `OPC_CONFIGURE) begin
                  tx_data_next = ok_reg ? `OPC_CONFIG_OK : `OPC_CONFIG_FAIL;
               end else begin
                  tx_data_next = `OPC_READ_REPLY;
               end
               state_next = st_tx_opcode;
            end
         end
         st_tx_opcode: begin
            if (tx_take) begin
               tx_data_next = {1'b0, own_addr};
               tx_last_next = (op_reg == `OPC_CONFIGURE);
               state_next = st_tx_module;
            end
         end
         st_tx_module: begin
            if (tx_take) begin
               tx_last_next = 1'b0;
               if (op_reg == `OPC_CONFIGURE) begin
                  state_next = st_dest;
               end else begin
                  astb_next = 1'b1;
                  state_next = st_rd_astb;
               end
            end
         end
         st_rd_astb: begin
            dstb_next = 1'b1;
            state_next = st_rd_dstb;
         end
         st_rd_dstb: begin
            tx_data_next = app_rdata_in;
            tx_last_next = (cnt_reg == 8'h01);
            state_next = st_tx_data;
         end
         st_tx_data: begin
            if (tx_take) begin
               cnt_next = cnt_reg - 8'h01;
               if (cnt_reg == 8'h01) begin
                  state_next = st_dest;
               end else begin
                  dstb_next = 1'b1;
                  state_next = st_rd_dstb;
               end
            end
         end
      endcase
   end

   always_ff @(posedge clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         state_reg <= st_dest;
         op_reg <= `BYTE_RESET;
         req_reg <= `ADDR_RESET;
         addr_reg <= `BYTE_RESET;
         data_reg <= `BYTE_RESET;
         cnt_reg <= `BYTE_RESET;
         first_reg <= 1'b0;
         last_reg <= 1'b0;
         ok_reg <= 1'b0;
         tx_data_reg <= `BYTE_RESET;
         tx_last_reg <= 1'b0;
         cfg_data_reg <= `BYTE_RESET;
         astb_reg <= 1'b0;
         dstb_reg <= 1'b0;
         write_reg <= 1'b0;
         cfg_valid_reg <= 1'b0;
         cfg_last_reg <= 1'b0;
      end else begin
         state_reg <= state_next;
         op_reg <= op_next;
         req_reg <= req_next;
         addr_reg <= addr_next;
         data_reg <= data_next;
         cnt_reg <= cnt_next;
         first_reg <= first_next;
         last_reg <= last_next;
         ok_reg <= ok_next;
         tx_data_reg <= tx_data_next;
         tx_last_reg <= tx_last_next;
         cfg_data_reg <= cfg_data_next;
         astb_reg <= astb_next;
         dstb_reg <= dstb_next;
         write_reg <= write_next;
         cfg_valid_reg <= cfg_valid_next;
         cfg_last_reg <= cfg_last_next;
      end
   end

   assign tx_data_out = tx_data_reg;
   assign tx_last_out = tx_last_reg;
   assign cfg_valid_out = cfg_valid_reg;
   assign cfg_data_out = cfg_data_reg;
   assign cfg_last_out = cfg_last_reg;
   assign app_addr_out = addr_reg;
   assign app_addr_stb_out = astb_reg;
   assign app_data_out = data_reg;
   assign app_data_stb_out = dstb_reg;
   assign app_write_out = write_reg;

   // ------------------------------------------------------------
   // assertions
   // ------------------------------------------------------------
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (!rstn_in);

   property p_no_write_reply;
      tx_valid_out |-> op_reg != `OPC_USER_WRITE;
   endproperty
   a_no_write_reply: assert property (p_no_write_reply) else $error("reply to a write");

   property p_write_order;
      (state_reg == st_wr_put) |-> app_addr_stb_out ##1 (app_data_stb_out && app_write_out);
   endproperty
   a_write_order: assert property (p_write_order) else $error("write strobe order");

   property p_write_more;
      (state_reg == st_wr_value && rx_take && !first_reg && !rx_last_in)
         |=> app_data_stb_out && app_write_out && app_data_out == $past(rx_data_in);
   endproperty
   a_write_more: assert property (p_write_more) else $error("value byte lost");

   property p_read_qual;
      (app_data_stb_out && op_reg == `OPC_USER_READ) |-> !app_write_out ##1 tx_valid_out;
   endproperty
   a_read_qual: assert property (p_read_qual) else $error("read qualifier");

   property p_cfg_reply;
      (state_reg == st_tx_opcode && op_reg == `OPC_CONFIGURE)
         |-> tx_data_out == (ok_reg ? `OPC_CONFIG_OK : `OPC_CONFIG_FAIL);
   endproperty
   a_cfg_reply: assert property (p_cfg_reply) else $error("config reply opcode");

   property p_read_reply;
      (state_reg == st_tx_opcode && op_reg == `OPC_USER_READ) |-> tx_data_out == `OPC_READ_REPLY;
   endproperty
   a_read_reply: assert property (p_read_reply) else $error("read reply opcode");

   property p_module_addr;
      (state_reg == st_tx_module) |-> tx_data_out == {1'b0, own_addr};
   endproperty
   a_module_addr: assert property (p_module_addr) else $error("module address");

   property p_foreign;
      (state_reg == st_dest && rx_take && !rx_last_in && rx_data_in != {1'b0, own_addr})
         |=> state_reg == st_skip;
   endproperty
   a_foreign: assert property (p_foreign) else $error("foreign frame taken");

   property p_read_count;
      (state_reg == st_tx_data) |-> tx_last_out == (cnt_reg == 8'h01);
   endproperty
   a_read_count: assert property (p_read_count) else $error("read byte count");

   property p_len_last;
      (state_reg == st_rd_len && rx_take && !rx_last_in) |=> state_reg == st_skip;
   endproperty
   a_len_last: assert property (p_len_last) else $error("long read accepted");

   c_write: cover property (state_reg == st_wr_put ##2 app_data_stb_out);
   c_read_multi: cover property (state_reg == st_tx_data && tx_take && cnt_reg == 8'h02);
   c_cfg_ok: cover property (state_reg == st_tx_opcode && tx_data_out == `OPC_CONFIG_OK);
   c_skip: cover property (state_reg == st_skip && rx_take && rx_last_in);
endmodule : serial_bus_user_access_bridge

// ==== rtl/bridge_map.svh ====
`ifndef BRIDGE_MAP_SVH
`define BRIDGE_MAP_SVH
// ------------------------------------------------------------
// message opcodes
// ------------------------------------------------------------
`define OPC_CONFIGURE 8'h03
`define OPC_CONFIG_OK 8'h05
`define OPC_CONFIG_FAIL 8'h06
`define OPC_USER_WRITE 8'h08
`define OPC_USER_READ 8'h09
`define OPC_READ_REPLY 8'h10
// ------------------------------------------------------------
// field positions and reset values
// ------------------------------------------------------------
`define BUS_ADDR_MSB 6
`define BOARD_FIELD_W 4
`define SLOT_FIELD_W 3
`define BYTE_RESET 8'h00
`define ADDR_RESET 7'h00
`define SYNC_STAGES_DEFAULT 2
`endif

// ==== rtl/bridge_pkg.sv ====
package bridge_pkg;
   typedef enum logic [4:0] {
      st_dest, st_opcode, st_requester, st_skip,
      st_cfg_byte, st_cfg_wait,
      st_wr_addr, st_wr_value, st_wr_put,
      st_rd_addr, st_rd_len,
      st_tx_dest, st_tx_opcode, st_tx_module,
      st_rd_astb, st_rd_dstb, st_tx_data
   } bridge_state_type;
endpackage : bridge_pkg

// ==== rtl/addr_sync.sv ====
`timescale 1ns/1ps
`include "bridge_map.svh"
module addr_sync #(
   parameter int WIDTH = 7,
   parameter int STAGES = `SYNC_STAGES_DEFAULT
) (
   input wire logic clk_in,
   input wire logic rstn_in,
   input wire logic [WIDTH-1:0] async_in,
   output logic [WIDTH-1:0] sync_out
);
   logic [WIDTH-1:0] stage_reg [STAGES];

   initial begin
      if (STAGES < 2 || WIDTH < 1) begin
         $error("addr_sync: needs at least two stages and one bit");
      end
   end

   // ------------------------------------------------------------
   // synchroniser chain
   // ------------------------------------------------------------
   always_ff @(posedge clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         for (int i = 0; i < STAGES; i++) begin
            stage_reg[i] <= '0;
         end
      end else begin
         stage_reg[0] <= async_in;
         for (int i = 1; i < STAGES; i++) begin
            stage_reg[i] <= stage_reg[i-1];
         end
      end
   end

   assign sync_out = stage_reg[STAGES-1];
endmodule : addr_sync

// ==== bench/app_side_model.sv ====
`timescale 1ns/1ps
module app_side_model (
   input wire logic clk_in,
   input wire logic rstn_in,
   input wire logic [7:0] app_addr_in,
   input wire logic app_addr_stb_in,
   input wire logic [7:0] app_data_in,
   input wire logic app_data_stb_in,
   input wire logic app_write_in,
   output logic [7:0] app_rdata_out,
   input wire logic cfg_last_in,
   input wire logic cfg_pass_in,
   output logic cfg_done_out,
   output logic cfg_ok_out
);
   logic [7:0] mem [0:255];
   logic [7:0] addr_reg;
   logic [2:0] wait_reg;
   initial begin
      for (int i = 0; i < 256; i++) begin
         mem[i] = 8'h00;
      end
   end
   // ------------------------------------------------------------
   // register file with self-incrementing address
   // ------------------------------------------------------------
   always @(posedge clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         addr_reg <= 8'h00;
         wait_reg <= 3'h0;
         cfg_done_out <= 1'b0;
      end else begin
         if (app_addr_stb_in) begin
            addr_reg <= app_addr_in;
         end
         if (app_data_stb_in) begin
            if (app_write_in) begin
               mem[addr_reg] <= app_data_in;
            end
            addr_reg <= addr_reg + 8'h01;
         end
         cfg_done_out <= (wait_reg == 3'h1);
         if (cfg_last_in) begin
            wait_reg <= 3'h4;
         end else if (wait_reg != 3'h0) begin
            wait_reg <= wait_reg - 3'h1;
         end
      end
   end
   // data only valid in a read strobe cycle, inverted otherwise
   assign app_rdata_out = (app_data_stb_in && !app_write_in) ? mem[addr_reg] : ~mem[addr_reg];
   assign cfg_ok_out = cfg_done_out ? cfg_pass_in : ~cfg_pass_in;
endmodule : app_side_model

// ==== bench/test_serial_bus_user_access_bridge.sv ====
`timescale 1ns/1ps
`include "bridge_map.svh"
module test_serial_bus_user_access_bridge;
   import bridge_pkg::*;
   typedef struct {
      logic [63:0] frm;
      int n;
      logic ok;
      int ntx;
      logic [7:0] op;
      int na;
      int nw;
      int nr;
      int nc;
   } row_type;
   localparam int LIMIT = 20000;
   localparam logic [3:0] BOARD = 4'h3;
   localparam logic [2:0] SLOT = 3'h2;
   logic clk_in = 1'b0;
   logic rstn_in = 1'b0;
   logic rx_valid_in = 1'b0;
   logic [7:0] rx_data_in = 8'h00;
   logic rx_last_in = 1'b0;
   logic tx_ready_in = 1'b0;
   logic cfg_pass = 1'b0;
   logic rx_ready_out, tx_valid_out, tx_last_out, cfg_valid_out, cfg_last_out;
   logic cfg_done_in, cfg_ok_in, app_addr_stb_out, app_data_stb_out, app_write_out;
   logic [7:0] tx_data_out, cfg_data_out, app_addr_out, app_data_out, app_rdata_in;
   logic [8:0] tx_q [$];
   int na, nw, nr, nc, cycles, mismatches, checks_done;
   logic [3:0] board = BOARD;
   logic [2:0] slot = SLOT;
   logic [8:0] cfg_w = 9'h000;
   row_type hand;
   row_type rows [0:11] = '{
      '{64'h1A085540A5000000, 5, 1'b0, 0, 8'h00, 1, 1, 0, 0},
      '{64'h1A09554001000000, 5, 1'b0, 4, `OPC_READ_REPLY, 1, 0, 1, 0},
      '{64'h1A0355C1C2000000, 5, 1'b1, 3, `OPC_CONFIG_OK, 0, 0, 0, 2},
      '{64'h1A0355C100000000, 4, 1'b0, 3, `OPC_CONFIG_FAIL, 0, 0, 0, 1},
      '{64'h1A03550000000000, 3, 1'b1, 3, `OPC_CONFIG_FAIL, 0, 0, 0, 0},
      '{64'h1B09554001000000, 5, 1'b0, 0, 8'h00, 0, 0, 0, 0},
      '{64'h1A01550000000000, 3, 1'b0, 0, 8'h00, 0, 0, 0, 0},
      '{64'h1A09554000000000, 5, 1'b0, 0, 8'h00, 0, 0, 0, 0},
      '{64'h1A09554001000000, 6, 1'b0, 0, 8'h00, 0, 0, 0, 0},
      '{64'h1A08554000000000, 4, 1'b0, 0, 8'h00, 0, 0, 0, 0},
      '{64'h1A0855FE11223300, 7, 1'b0, 0, 8'h00, 1, 3, 0, 0},
      '{64'h1A0955FE03000000, 5, 1'b0, 6, `OPC_READ_REPLY, 1, 0, 3, 0}};
   always #5 clk_in = ~clk_in;
   serial_bus_user_access_bridge u_serial_bus_user_access_bridge (.clk_in(clk_in),
      .rstn_in(rstn_in), .board_num_in(board), .slot_num_in(slot), .rx_valid_in(rx_valid_in),
      .rx_data_in(rx_data_in), .rx_last_in(rx_last_in), .rx_ready_out(rx_ready_out),
      .tx_valid_out(tx_valid_out), .tx_data_out(tx_data_out), .tx_last_out(tx_last_out),
      .tx_ready_in(tx_ready_in), .cfg_valid_out(cfg_valid_out), .cfg_data_out(cfg_data_out),
      .cfg_last_out(cfg_last_out), .cfg_done_in(cfg_done_in), .cfg_ok_in(cfg_ok_in),
      .app_addr_out(app_addr_out), .app_addr_stb_out(app_addr_stb_out),
      .app_data_out(app_data_out), .app_data_stb_out(app_data_stb_out),
      .app_write_out(app_write_out), .app_rdata_in(app_rdata_in));
   app_side_model u_app_side_model (.clk_in(clk_in), .rstn_in(rstn_in),
      .app_addr_in(app_addr_out), .app_addr_stb_in(app_addr_stb_out),
      .app_data_in(app_data_out), .app_data_stb_in(app_data_stb_out),
      .app_write_in(app_write_out), .app_rdata_out(app_rdata_in), .cfg_last_in(cfg_last_out),
      .cfg_pass_in(cfg_pass), .cfg_done_out(cfg_done_in), .cfg_ok_out(cfg_ok_in));
   // ------------------------------------------------------------
   // monitors, stalling reply link and timeout
   // ------------------------------------------------------------
   always @(posedge clk_in) begin
      tx_ready_in <= ~tx_ready_in;
      if (tx_valid_out === 1'b1 && tx_ready_in === 1'b1) tx_q.push_back({tx_last_out, tx_data_out});
      if (app_addr_stb_out === 1'b1) na++;
      if (app_data_stb_out === 1'b1 && app_write_out === 1'b1) nw++;
      if (app_data_stb_out === 1'b1 && app_write_out === 1'b0) nr++;
      if (cfg_valid_out === 1'b1) nc++;
      if (cfg_valid_out === 1'b1) cfg_w = {cfg_last_out, cfg_data_out};
      cycles++;
      if (cycles == LIMIT) begin
         mismatches++;
         conclude();
      end
   end
   // ------------------------------------------------------------
   // tasks
   // ------------------------------------------------------------
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         mismatches++;
         $display("BAD at %0t: saw %0h expected %0h", $time, seen, exp);
      end
   endtask : check
   task automatic send(input logic [7:0] b, input logic l);
      logic rdy;
      rx_valid_in <= 1'b1;
      rx_data_in <= b;
      rx_last_in <= l;
      rdy = 1'b0;
      while (!rdy) begin
         @(negedge clk_in);
         rdy = (rx_ready_out === 1'b1);
         @(posedge clk_in);
      end
   endtask : send
   task automatic run(input row_type r);
      int k;
      tx_q.delete();
      na = 0;
      nw = 0;
      nr = 0;
      nc = 0;
      cfg_pass <= r.ok;
      for (k = 0; k < r.n; k++) send(r.frm[63 - 8 * k -: 8], k == r.n - 1);
      rx_valid_in <= 1'b0;
      for (k = 0; k < 300 && tx_q.size() < r.ntx; k++) @(posedge clk_in);
      repeat (12) @(posedge clk_in);
      check(tx_q.size(), r.ntx);
      check(na, r.na);
      check(nw, r.nw);
      check(nr, r.nr);
      check(nc, r.nc);
      if (r.nc > 0) check(cfg_w, {1'b1, r.frm[71 - 8 * r.n -: 8]});
      if (r.ntx > 0 && tx_q.size() == r.ntx) begin
         check(tx_q[0], {1'b0, 8'h55});
         check(tx_q[1], {1'b0, r.op});
         check(tx_q[2][7:0], {1'b0, board, slot});
         check(tx_q[r.ntx - 1][8], 1'b1);
      end
   endtask : run
   task automatic conclude;
      $display("checks_done %0d mismatches %0d", checks_done, mismatches);
      if (mismatches == 0 && checks_done > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask : conclude
   // ------------------------------------------------------------
   // main sequence
   // ------------------------------------------------------------
   initial begin
      repeat (10) @(posedge clk_in);
      @(negedge clk_in);
      check({rx_ready_out, tx_valid_out, cfg_valid_out, app_addr_stb_out}, 4'h8);
      check({app_data_stb_out, app_write_out, tx_last_out, cfg_last_out}, 4'h0);
      repeat (10) @(posedge clk_in);
      rstn_in <= 1'b1;
      repeat (3) @(posedge clk_in);
      for (int i = 0; i < 12; i++) run(rows[i]);
      check(tx_q[3], {1'b0, 8'h11});
      check(tx_q[4], {1'b0, 8'h22});
      check(tx_q[5], {1'b1, 8'h33});
      // ------------------------------------------------------------
      // reset inside a frame, then a moved bus address
      // ------------------------------------------------------------
      send(8'h1A, 1'b0);
      send(`OPC_CONFIGURE, 1'b0);
      rx_valid_in <= 1'b0;
      rstn_in <= 1'b0;
      board <= 4'h5;
      slot <= 3'h1;
      repeat (2) @(negedge clk_in);
      check({rx_ready_out, tx_valid_out, cfg_valid_out, app_data_stb_out}, 4'h8);
      @(posedge clk_in);
      rstn_in <= 1'b1;
      repeat (3) @(posedge clk_in);
      hand = '{64'h1A09554001000000, 5, 1'b0, 0, 8'h00, 0, 0, 0, 0};
      run(hand);
      hand = '{64'h2909554001000000, 5, 1'b0, 4, `OPC_READ_REPLY, 1, 0, 1, 0};
      run(hand);
      check(tx_q[3], {1'b1, 8'hA5});
      conclude();
   end
endmodule : test_serial_bus_user_access_bridge
